// ==== rtl/adcsp_regs.vh ====
// Register offsets, field positions, reset values and frame counts for the converter serial port
`ifndef ADCSP_REGS_VH
`define ADCSP_REGS_VH

`define ADCSP_ADDR_W        8
`define ADCSP_OFF_CTRL      8'h00
`define ADCSP_OFF_TEST_DATA 8'h04
`define ADCSP_OFF_CONFIG    8'h08
`define ADCSP_OFF_STATUS    8'h0c
`define ADCSP_OFF_RESULT    8'h10
`define ADCSP_OFF_FRAMES    8'h14

`define ADCSP_CTRL_ENABLE_BIT   0
`define ADCSP_CTRL_TESTSRC_BIT  1
`define ADCSP_CTRL_RESET        2'h1
`define ADCSP_TEST_DATA_RESET   12'h000

`define ADCSP_CFG_W             8
`define ADCSP_CFG_RESET         8'h00
`define ADCSP_CFG_DUAL_BIT      4
`define ADCSP_CFG_PICK_BIT      3
`define ADCSP_CFG_PM_HI         1
`define ADCSP_CFG_PM_LO         0
`define ADCSP_PM_DEFAULT        2'h0

`define ADCSP_STAT_ACTIVE_BIT   0
`define ADCSP_STAT_TRACK_BIT    1
`define ADCSP_STAT_POWER_BIT    2
`define ADCSP_STAT_ABORT_BIT    3
`define ADCSP_STAT_COUNT_LO     8
`define ADCSP_STAT_EXTRA_BIT    4
`define ADCSP_STAT_FALLS_LO     16
`define ADCSP_FRAMES_ABORT_LO   16

`define ADCSP_RES_W             12
`define ADCSP_LEAD_ZEROS        4
`define ADCSP_FRAME_BITS        16
`define ADCSP_CNT_W             5
`define ADCSP_CFG_EDGES         5'h08
`define ADCSP_LAST_EDGE         5'h0f
`define ADCSP_FRAME_EDGES       5'h10

`endif

// ==== rtl/adcsp_sync.v ====
// Three-stage pin synchroniser; output follows once stages two and three agree
module adcsp_sync #(
    parameter W = 3
) (
    input  wire         mclk_i,
    input  wire         reset_i,
    input  wire [W-1:0] pin_i,
    input  wire [W-1:0] rst_val_i,
    output wire [W-1:0] clean_o
);

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg s1;
            reg s2;
            reg s3;
            reg clean;
            always @(posedge mclk_i) begin
                if (reset_i) begin
                    // Stages start at the idle level so no false edge follows reset
                    s1    <= rst_val_i[g];
                    s2    <= rst_val_i[g];
                    s3    <= rst_val_i[g];
                    clean <= rst_val_i[g];
                end else begin
                    // First stage feeds only the second
                    s1 <= pin_i[g];
                    s2 <= s1;
                    s3 <= s2;
                    if (s2 == s3) begin
                        clean <= s3;
                    end
                end
            end
            // Reset value forced out until stages two and three first agree
            reg filled;
            always @(posedge mclk_i) begin
                if (reset_i) begin
                    filled <= 1'b0;
                end else if (s2 == s3) begin
                    filled <= 1'b1;
                end
            end
            assign clean_o[g] = filled ? clean : rst_val_i[g];
        end
    endgenerate

endmodule

// ==== rtl/adcsp_port.v ====
// Serial port, configuration register and conversion sequencing of the two-input converter
`include "adcsp_regs.vh"

module adcsp_port (
    input  wire                       mclk_i,
    input  wire                       reset_i,
    // Serial pins
    input  wire                       sel_n_i,
    input  wire                       sclk_i,
    input  wire                       din_i,
    output reg                        dout_o,
    output reg                        dout_oe_o,
    // Analog core
    input  wire [`ADCSP_RES_W-1:0]    conv_data_i,
    output reg                        track_o,
    output reg                        power_up_o,
    output reg                        second_input_or_bias_pin_o,
    output reg                        input_pick_o,
    // APB
    input  wire                       psel_i,
    input  wire                       penable_i,
    input  wire                       pwrite_i,
    input  wire [`ADCSP_ADDR_W-1:0]   paddr_i,
    input  wire [31:0]                pwdata_i,
    output reg  [31:0]                prdata_o,
    output reg                        pready_o,
    output reg                        pslverr_o
);

    wire [2:0]                 pins_clean;
    wire                       sel_n_c;
    wire                       sclk_c;
    wire                       din_c;

    reg                        sel_n_p;
    reg                        sclk_p;
    reg                        frame_active;
    reg  [`ADCSP_CNT_W-1:0]    rise_cnt;
    reg  [`ADCSP_CFG_W-2:0]    cfg_shift;
    reg  [`ADCSP_CFG_W-1:0]    config_word;
    reg  [`ADCSP_FRAME_BITS-1:0] out_shift;
    reg  [`ADCSP_RES_W-1:0]    last_result;
    reg  [15:0]                frame_count;
    reg                        abort_flag;
    reg                        extra_flag;
    reg  [`ADCSP_CNT_W-1:0]    fall_cnt;
    reg  [15:0]                abort_count;

    reg  [1:0]                 ctrl;
    reg  [`ADCSP_RES_W-1:0]    test_data;

    wire                       sel_fall;
    wire                       sel_rise;
    wire                       sclk_rise;
    wire                       sclk_fall;
    wire                       enabled;
    wire [`ADCSP_RES_W-1:0]    sample_value;
    wire [1:0]                 power_mode_bits;
    wire                       channel_count_select;
    wire                       input_pick;
    wire                       apb_setup;
    wire                       apb_write;
    wire                       abort_event;
    wire                       abort_clear;
    wire                       extra_event;
    wire                       extra_clear;

    reg  [31:0]                next_prdata;
    reg                        next_slverr;

    // Select idles high so the port stays quiet through reset
    adcsp_sync #(
        .W (3)
    ) u_sync (
        .mclk_i    (mclk_i),
        .reset_i   (reset_i),
        .pin_i     ({din_i, sclk_i, sel_n_i}),
        .rst_val_i (3'h1),
        .clean_o   (pins_clean)
    );

    assign sel_n_c = pins_clean[0];
    assign sclk_c  = pins_clean[1];
    assign din_c   = pins_clean[2];

    always @(posedge mclk_i) begin
        if (reset_i) begin
            sel_n_p <= 1'b1;
            sclk_p  <= 1'b0;
        end else begin
            sel_n_p <= sel_n_c;
            sclk_p  <= sclk_c;
        end
    end

    assign sel_fall  = sel_n_p & ~sel_n_c;
    assign sel_rise  = ~sel_n_p & sel_n_c;
    assign sclk_rise = ~sclk_p & sclk_c;
    assign sclk_fall = sclk_p & ~sclk_c;
    assign enabled   = ctrl[`ADCSP_CTRL_ENABLE_BIT];

    assign sample_value = ctrl[`ADCSP_CTRL_TESTSRC_BIT] ? test_data : conv_data_i;

    assign power_mode_bits      = config_word[`ADCSP_CFG_PM_HI:`ADCSP_CFG_PM_LO];
    assign channel_count_select = config_word[`ADCSP_CFG_DUAL_BIT];
    // Input choice only means something in dual mode
    assign input_pick           = channel_count_select & config_word[`ADCSP_CFG_PICK_BIT];

    // Frame sequencing; everything is timed by select and serial clock edges, not by mclk
    always @(posedge mclk_i) begin
        if (reset_i) begin
            frame_active <= 1'b0;
            rise_cnt     <= {`ADCSP_CNT_W{1'b0}};
            cfg_shift    <= {(`ADCSP_CFG_W-1){1'b0}};
            config_word  <= `ADCSP_CFG_RESET;
            out_shift    <= {`ADCSP_FRAME_BITS{1'b0}};
            last_result  <= {`ADCSP_RES_W{1'b0}};
            frame_count  <= 16'h0000;
            dout_o       <= 1'b0;
            dout_oe_o    <= 1'b0;
            track_o      <= 1'b1;
            input_pick_o <= 1'b0;
        end else if (sel_rise) begin
            // Early rise aborts; sampler goes back to tracking at once
            frame_active <= 1'b0;
            dout_oe_o    <= 1'b0;
            dout_o       <= 1'b0;
            track_o      <= 1'b1;
        end else if (sel_fall && enabled) begin
            frame_active <= 1'b1;
            rise_cnt     <= {`ADCSP_CNT_W{1'b0}};
            track_o      <= 1'b0;
            out_shift    <= {{`ADCSP_LEAD_ZEROS{1'b0}}, sample_value};
            last_result  <= sample_value;
            dout_o       <= 1'b0;
            dout_oe_o    <= 1'b1;
            input_pick_o <= input_pick;
        end else if (frame_active) begin
            if (sclk_rise && rise_cnt < `ADCSP_FRAME_EDGES) begin
                rise_cnt <= rise_cnt + 5'h01;
                if (rise_cnt < `ADCSP_CFG_EDGES - 5'h01) begin
                    cfg_shift <= {cfg_shift[`ADCSP_CFG_W-3:0], din_c};
                end else if (rise_cnt == `ADCSP_CFG_EDGES - 5'h01) begin
                    // Eighth edge completes the word; later bits are dropped
                    config_word <= {cfg_shift, din_c};
                end
                if (rise_cnt == `ADCSP_LAST_EDGE) begin
                    track_o     <= 1'b1;
                    frame_count <= frame_count + 16'h0001;
                end
            end
            // A fall moves data only once its own rise was seen
            if (sclk_fall && fall_cnt < rise_cnt && fall_cnt < `ADCSP_LAST_EDGE) begin
                dout_o    <= out_shift[`ADCSP_FRAME_BITS-2];
                out_shift <= {out_shift[`ADCSP_FRAME_BITS-2:0], 1'b0};
            end
        end
    end

    // Pin roles and power follow the configuration
    always @(posedge mclk_i) begin
        if (reset_i) begin
            power_up_o                 <= 1'b0;
            second_input_or_bias_pin_o <= 1'b0;
        end else begin
            // Other power modes keep the core up; only the default sleeps while select is high
            power_up_o                 <= (power_mode_bits != `ADCSP_PM_DEFAULT) | ~sel_n_c;
            second_input_or_bias_pin_o <= channel_count_select;
        end
    end

    // Abort flag: short frame seen; set wins over a software clear
    assign abort_event = sel_rise & frame_active & (rise_cnt != `ADCSP_FRAME_EDGES);
    assign apb_setup   = psel_i & ~penable_i;
    assign apb_write   = psel_i & penable_i & pready_o & pwrite_i;
    assign abort_clear = apb_write & (paddr_i == `ADCSP_OFF_STATUS) & pwdata_i[`ADCSP_STAT_ABORT_BIT];

    always @(posedge mclk_i) begin
        if (reset_i) begin
            abort_flag <= 1'b0;
        end else if (abort_event) begin
            abort_flag <= 1'b1;
        end else if (abort_clear) begin
            abort_flag <= 1'b0;
        end
    end

    // Rises past the sixteenth are ignored but flagged; set wins over a clear
    assign extra_event = frame_active & sclk_rise & (rise_cnt == `ADCSP_FRAME_EDGES);
    assign extra_clear = apb_write & (paddr_i == `ADCSP_OFF_STATUS) & pwdata_i[`ADCSP_STAT_EXTRA_BIT];

    always @(posedge mclk_i) begin
        if (reset_i) begin
            extra_flag <= 1'b0;
        end else if (extra_event) begin
            extra_flag <= 1'b1;
        end else if (extra_clear) begin
            extra_flag <= 1'b0;
        end
    end

    // Falls counted apart from rises so a stray fall before a rise moves nothing
    always @(posedge mclk_i) begin
        if (reset_i) begin
            fall_cnt <= {`ADCSP_CNT_W{1'b0}};
        end else if (sel_fall) begin
            fall_cnt <= {`ADCSP_CNT_W{1'b0}};
        end else if (frame_active && sclk_fall && fall_cnt < rise_cnt) begin
            fall_cnt <= fall_cnt + 5'h01;
        end
    end

    // Short frames counted too: the flag alone hides repeats
    always @(posedge mclk_i) begin
        if (reset_i) begin
            abort_count <= 16'h0000;
        end else if (abort_event) begin
            abort_count <= abort_count + 16'h0001;
        end
    end

    // APB registers
    always @(posedge mclk_i) begin
        if (reset_i) begin
            ctrl      <= `ADCSP_CTRL_RESET;
            test_data <= `ADCSP_TEST_DATA_RESET;
        end else if (apb_write) begin
            if (paddr_i == `ADCSP_OFF_CTRL) begin
                ctrl <= pwdata_i[1:0];
            end
            if (paddr_i == `ADCSP_OFF_TEST_DATA) begin
                test_data <= pwdata_i[`ADCSP_RES_W-1:0];
            end
        end
    end

    always @* begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (paddr_i)
            `ADCSP_OFF_CTRL: begin
                next_prdata[1:0] = ctrl;
            end
            `ADCSP_OFF_TEST_DATA: begin
                next_prdata[`ADCSP_RES_W-1:0] = test_data;
            end
            `ADCSP_OFF_CONFIG: begin
                next_prdata[`ADCSP_CFG_W-1:0] = config_word;
            end
            `ADCSP_OFF_STATUS: begin
                next_prdata[`ADCSP_STAT_ACTIVE_BIT] = frame_active;
                next_prdata[`ADCSP_STAT_TRACK_BIT]  = track_o;
                next_prdata[`ADCSP_STAT_POWER_BIT]  = power_up_o;
                next_prdata[`ADCSP_STAT_ABORT_BIT]  = abort_flag;
                next_prdata[`ADCSP_STAT_EXTRA_BIT]  = extra_flag;
                next_prdata[`ADCSP_STAT_FALLS_LO+`ADCSP_CNT_W-1:`ADCSP_STAT_FALLS_LO] = fall_cnt;
                next_prdata[`ADCSP_STAT_COUNT_LO+`ADCSP_CNT_W-1:`ADCSP_STAT_COUNT_LO] = rise_cnt;
            end
            `ADCSP_OFF_RESULT: begin
                next_prdata[`ADCSP_RES_W-1:0] = last_result;
            end
            `ADCSP_OFF_FRAMES: begin
                next_prdata[15:0] = frame_count;
                next_prdata[`ADCSP_FRAMES_ABORT_LO+15:`ADCSP_FRAMES_ABORT_LO] = abort_count;
            end
            default: begin
                next_slverr = 1'b1;
            end
        endcase
    end

    // Answer always one cycle after setup: access phase is exactly one cycle
    always @(posedge mclk_i) begin
        if (reset_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= apb_setup;
            pslverr_o <= apb_setup & next_slverr;
            if (apb_setup && !pwrite_i) begin
                prdata_o <= next_prdata;
            end
        end
    end

endmodule

// ==== tb/adcsp_chk.sv ====
// Serial port checker, bound to the converter port top module
module adcsp_chk (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic sel_n_i,
    input wire logic sclk_i,
    input wire logic dout_o,
    input wire logic dout_oe_o,
    input wire logic track_o,
    input wire logic power_up_o,
    input wire logic second_input_or_bias_pin_o,
    input wire logic input_pick_o,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o
);
    logic [4:0] rise_cnt;
    logic       sclk_q;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // Pin-level count of rises in the frame
    always @(posedge mclk_i) begin
        sclk_q <= sclk_i;
        if (reset_i || sel_n_i)
            rise_cnt <= 5'h00;
        else if (sclk_i && !sclk_q)
            rise_cnt <= rise_cnt + 5'h01;
    end

    a_oe_idle: assert property (sel_n_i [*8] |-> !dout_oe_o)
        else $error("output driven while deselected");
    a_oe_start: assert property ($fell(sel_n_i) |-> ##[1:8] dout_oe_o)
        else $error("output not enabled after select fall");
    a_power_on: assert property ($fell(sel_n_i) |-> ##[1:8] power_up_o)
        else $error("core not powered in frame");
    a_lead_zero: assert property ($rose(dout_oe_o) |-> !dout_o [*8])
        else $error("frame does not open with zeros");
    a_fall_hold: assert property ($fell(sclk_i) |=> $stable(dout_o) [*3])
        else $error("data out moved too soon");
    a_hold_start: assert property ($fell(sel_n_i) |-> ##[1:8] !track_o)
        else $error("sampler not holding");
    a_track_back: assert property ($rose(sclk_i) && rise_cnt == 5'h0f |-> ##[1:8] track_o)
        else $error("sampler not back to tracking");
    a_pin_role: assert property ($changed(second_input_or_bias_pin_o) |-> !sel_n_i)
        else $error("pin role changed outside frame");
    a_pick_fall: assert property ($changed(input_pick_o) |-> !sel_n_i && $past(sel_n_i, 8))
        else $error("input pick changed off select fall");
    a_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
endmodule

bind adcsp_port adcsp_chk adcsp_chk_i (.mclk_i, .reset_i, .sel_n_i, .sclk_i, .dout_o, .dout_oe_o,
    .track_o, .power_up_o, .second_input_or_bias_pin_o, .input_pick_o, .psel_i, .penable_i, .pready_o);

// ==== tb/adcsp_host.sv ====
// Host serial controller model: select, serial clock and data in
module adcsp_host (
    input  wire logic mclk_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_i,
    output logic      sel_n_o,
    output logic      sclk_o,
    output logic      din_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sel_n_o = 1'b1;
        sclk_o  = 1'b0;
        din_o   = 1'b0;
    end

    // Clock stands low between frames; caller enters just after an edge
    task automatic frame(input logic [7:0] cfg, input int nrise, output logic [15:0] got);
        got = 16'h0000;
        sel_n_o <= 1'b0;
        repeat (8) @(posedge mclk_i);
        for (int k = 0; k < nrise; k++) begin
            din_o <= (k < 8) ? cfg[7-k] : ~din_o;
            repeat (4) @(posedge mclk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge mclk_i);
            // Late capture: the sampled port answers some cycles after each fall
            // Released line reads back inverted so a dropped enable shows
            got = {got[14:0], dout_oe_i ? dout_i : ~dout_i};
            sclk_o <= 1'b0;
        end
        repeat (8) @(posedge mclk_i);
        sel_n_o <= 1'b1;
        din_o   <= ~din_o;
        repeat (12) @(posedge mclk_i);
    endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the converter serial port
`include "adcsp_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        sel_n_i, sclk_i, din_i, dout_o, dout_oe_o;
    logic        track_o, power_up_o, second_input_or_bias_pin_o, input_pick_o;
    logic [11:0] conv_data_i;
    logic        psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
    logic [7:0]  paddr_i, cfg, prev;
    logic [31:0] pwdata_i, prdata_o, r;
    logic [23:0] td;
    logic [15:0] got;
    integer      seed;
    int          err_total, checks_done, fr;

    always #5 mclk_i = ~mclk_i;

    adcsp_port adcsp_port_i (.mclk_i, .reset_i, .sel_n_i, .sclk_i, .din_i, .dout_o, .dout_oe_o,
        .conv_data_i, .track_o, .power_up_o, .second_input_or_bias_pin_o, .input_pick_o, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
    adcsp_host adcsp_host_i (.mclk_i, .dout_i(dout_o), .dout_oe_i(dout_oe_o), .sel_n_o(sel_n_i), .sclk_o(sclk_i),
        .din_o(din_i));

    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // Frame word: four zeros, then the chosen source's twelve bits
    function automatic logic [15:0] exp_frame(input logic src, input logic [23:0] t);
        return {4'h0, src ? t[11:0] : t[23:12]};
    endfunction

    // Input pick only counts in dual mode
    function automatic logic exp_pick(input logic [7:0] c);
        return c[4] & c[3];
    endfunction

    // One APB transfer; an idle edge follows so calls never collide
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        penable_i <= 1'b0;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                tally_and_finish();
            end
            @(posedge mclk_i);
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    initial begin
        seed = 32'h9acef29e;
        {psel_i, penable_i, pwrite_i} = 3'b000;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        conv_data_i = 12'h000;
        prev = 8'h00;
        repeat (5) @(posedge mclk_i);
        reset_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        apb(1'b0, `ADCSP_OFF_CONFIG, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk(e, 1'b1);
        chk(r, 32'h0);
        for (int i = 0; i < 5; i++) begin
            cfg = (8'($random(seed)) & 8'he7) | 8'((i - 1) * 8);
            if (i == 0)
                cfg = 8'h00;
            td = 24'($random(seed));
            conv_data_i <= td[23:12];
            apb(1'b1, `ADCSP_OFF_CTRL, {30'h0, i[0], 1'b1});
            apb(1'b1, `ADCSP_OFF_TEST_DATA, {20'h0, td[11:0]});
            adcsp_host_i.frame(cfg, 16, got);
            fr++;
            chk(got, exp_frame(i[0], td));
            chk(input_pick_o, exp_pick(prev));
            chk(second_input_or_bias_pin_o, cfg[4]);
            chk(power_up_o, cfg[1:0] != 2'h0);
            chk(track_o, 1'b1);
            apb(1'b0, `ADCSP_OFF_CONFIG, 32'h0);
            chk(r, cfg);
            apb(1'b0, `ADCSP_OFF_RESULT, 32'h0);
            chk(r, exp_frame(i[0], td));
            prev = cfg;
        end
        // Select lifted after five clocks: the config must not load and the frame count must not move
        adcsp_host_i.frame(8'h13, 5, got);
        chk(input_pick_o, exp_pick(prev));
        apb(1'b0, `ADCSP_OFF_STATUS, 32'h0);
        chk(r[3], 1'b1);
        chk(r[12:8], 5'h05);
        chk(r[20:16], 5'h05);
        apb(1'b0, `ADCSP_OFF_CONFIG, 32'h0);
        chk(r, prev);
        apb(1'b0, `ADCSP_OFF_FRAMES, 32'h0);
        chk(r[15:0], fr);
        chk(r[31:16], 16'h0001);
        // Seventeen rises: the extra one is flagged and counts nothing
        adcsp_host_i.frame(prev, 17, got);
        fr++;
        apb(1'b0, `ADCSP_OFF_STATUS, 32'h0);
        chk(r[4], 1'b1);
        chk(r[12:8], 5'h10);
        apb(1'b0, `ADCSP_OFF_FRAMES, 32'h0);
        chk(r[15:0], fr);
        apb(1'b1, `ADCSP_OFF_STATUS, 32'h18);
        apb(1'b0, `ADCSP_OFF_STATUS, 32'h0);
        chk(r[3], 1'b0);
        chk(r[4], 1'b0);
        tally_and_finish();
    end
endmodule
